// ==== rtl/quiro_pkg.sv ====
/*
 * Constants, types and register map for the quad UART interrupt and ready
 * output block. Assumes one clock (pclk, 100 MHz) and an APB register bus.
 */
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package quiro_pkg;

	localparam int NUM_CH = 4;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int MCR_W  = 8;

	// ------------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_MCR_A    = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_MCR_B    = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_MCR_C    = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_MCR_D    = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_DMA_MODE = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_INT_STAT = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_INT_MASK = 8'h1c;

	// ------------------------------------------------------------------------
	// Fields and reset values
	// ------------------------------------------------------------------------
	localparam int                 MCR_IRQ_EN_BIT = 3;
	localparam logic [MCR_W-1:0]   MCR_RESET      = 8'h00;
	localparam logic [NUM_CH-1:0]  DMA_RESET      = 4'h0;
	localparam int                 EV_W           = 5;
	localparam int                 EV_MODE_BIT    = 4;
	localparam logic [EV_W-1:0]    INT_STAT_RESET = 5'h00;
	localparam logic [EV_W-1:0]    INT_MASK_RESET = 5'h00;
	localparam int                 ST_TX_LSB      = 0;
	localparam int                 ST_RX_LSB      = 4;
	localparam int                 ST_MODE_BIT    = 8;
	localparam int                 ST_OVR_BIT     = 9;
	localparam logic [DATA_W-1:0]  ZERO_WORD      = 32'h0000_0000;

	typedef enum logic {
		QUIRO_MODE_SINGLE,
		QUIRO_MODE_SEPARATE
	} quiro_bus_mode_t;

	typedef enum logic [1:0] {
		QUIRO_OVR_PIN,
		QUIRO_OVR_TIE_HIGH,
		QUIRO_OVR_TIE_LOW
	} quiro_ovr_tie_t;

	typedef enum logic {
		QUIRO_RDY_IDLE,
		QUIRO_RDY_ACTIVE
	} quiro_rdy_state_t;

endpackage

// ==== rtl/quiro_sync.sv ====
/*
 * Three-stage pin synchroniser; the output changes only when stages two
 * and three agree. Assumes the input is asynchronous to pclk.
 */
`timescale 1ns/10ps
module quiro_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic pin_in,
	output logic      level_out
);
	import quiro_pkg::*;

	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg <= RESET_VAL;
			s2_reg <= RESET_VAL;
			s3_reg <= RESET_VAL;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_out <= RESET_VAL;
		end else if (s2_reg == s3_reg) begin
			level_out <= s3_reg;
		end
	end

	a_sync_agree: assert property (@(posedge pclk) disable iff (!presetn)
		(level_out != $past(level_out)) |-> ($past(s2_reg) == $past(s3_reg)))
		else $error("synchroniser output changed without agreement");

endmodule

// ==== rtl/quiro_ready.sv ====
/*
 * One channel's transmit-ready and receive-ready logic, classic DMA mode 0
 * and mode 1. Assumes status inputs come from the UART core on pclk.
 */
`timescale 1ns/10ps
module quiro_ready (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic dma_mode,
	input  wire logic thr_empty,
	input  wire logic tx_fifo_full,
	input  wire logic rx_data_avail,
	input  wire logic rx_trig_hit,
	output logic      tx_ready_n_next,
	output logic      rx_ready_n_next,
	output logic      tx_ready_n_reg,
	output logic      rx_ready_n_reg
);
	import quiro_pkg::*;

	quiro_rdy_state_t tx_state_reg;
	quiro_rdy_state_t tx_state_next;
	quiro_rdy_state_t rx_state_reg;
	quiro_rdy_state_t rx_state_next;

	// ------------------------------------------------------------------------
	// Transmit: mode 0 tracks emptiness, mode 1 holds until full
	// ------------------------------------------------------------------------
	always_comb begin
		tx_state_next = tx_state_reg;
		case (tx_state_reg)
			QUIRO_RDY_IDLE:   if (thr_empty) tx_state_next = QUIRO_RDY_ACTIVE;
			QUIRO_RDY_ACTIVE: begin
				if (dma_mode ? tx_fifo_full : !thr_empty) begin
					tx_state_next = QUIRO_RDY_IDLE;
				end
			end
			default:          tx_state_next = QUIRO_RDY_IDLE;
		endcase
		tx_ready_n_next = (tx_state_next != QUIRO_RDY_ACTIVE);
	end

	// ------------------------------------------------------------------------
	// Receive: mode 0 on any data, mode 1 on trigger until empty
	// ------------------------------------------------------------------------
	always_comb begin
		rx_state_next = rx_state_reg;
		case (rx_state_reg)
			QUIRO_RDY_IDLE: begin
				if (dma_mode ? rx_trig_hit : rx_data_avail) begin
					rx_state_next = QUIRO_RDY_ACTIVE;
				end
			end
			QUIRO_RDY_ACTIVE: if (!rx_data_avail) rx_state_next = QUIRO_RDY_IDLE;
			default:          rx_state_next = QUIRO_RDY_IDLE;
		endcase
		rx_ready_n_next = (rx_state_next != QUIRO_RDY_ACTIVE);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_state_reg   <= QUIRO_RDY_IDLE;
			rx_state_reg   <= QUIRO_RDY_IDLE;
			tx_ready_n_reg <= 1'b1;
			rx_ready_n_reg <= 1'b1;
		end else begin
			tx_state_reg   <= tx_state_next;
			rx_state_reg   <= rx_state_next;
			tx_ready_n_reg <= tx_ready_n_next;
			rx_ready_n_reg <= rx_ready_n_next;
		end
	end

	a_rx_hold_m1: assert property (@(posedge pclk) disable iff (!presetn)
		(dma_mode && !rx_ready_n_reg && rx_data_avail) |=> !rx_ready_n_reg)
		else $error("mode 1 receive-ready released while data remain");

endmodule

// ==== rtl/quiro_top.sv ====
/*
 * Interrupt pin and FIFO-ready pin logic of a four-channel UART with an APB
 * register file. Assumes pending-interrupt and FIFO status inputs come from
 * the UART cores on pclk; bus-mode and override inputs are asynchronous pins.
 */
`timescale 1ns/10ps
module quiro_top #(
	parameter quiro_pkg::quiro_ovr_tie_t OVR_TIE = quiro_pkg::QUIRO_OVR_PIN
) (
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic [quiro_pkg::ADDR_W-1:0]  paddr,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [quiro_pkg::DATA_W-1:0]  pwdata,
	output logic      [quiro_pkg::DATA_W-1:0]  prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic                          bus_mode_select,
	input  wire logic                          irq_override_select,
	input  wire logic [quiro_pkg::NUM_CH-1:0]  chan_irq_pending,
	input  wire logic [quiro_pkg::NUM_CH-1:0]  thr_empty,
	input  wire logic [quiro_pkg::NUM_CH-1:0]  tx_fifo_full,
	input  wire logic [quiro_pkg::NUM_CH-1:0]  rx_data_avail,
	input  wire logic [quiro_pkg::NUM_CH-1:0]  rx_trig_hit,
	output logic                               chan_a_irq_out,
	output logic                               chan_a_irq_oe,
	output logic                               chan_b_irq_out,
	output logic                               chan_b_irq_oe,
	output logic                               chan_c_irq_out,
	output logic                               chan_c_irq_oe,
	output logic                               chan_d_irq_out,
	output logic                               chan_d_irq_oe,
	output logic                               chan_a_tx_ready_n,
	output logic                               chan_b_tx_ready_n,
	output logic                               chan_c_tx_ready_n,
	output logic                               chan_d_tx_ready_n,
	output logic                               chan_a_rx_ready_n,
	output logic                               chan_b_rx_ready_n,
	output logic                               chan_c_rx_ready_n,
	output logic                               chan_d_rx_ready_n,
	output logic                               all_tx_ready_n,
	output logic                               all_rx_ready_n,
	output logic                               irq
);
	import quiro_pkg::*;

	// ------------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------------
	logic [MCR_W-1:0]  modem_control_reg [NUM_CH];
	logic [NUM_CH-1:0] dma_mode_reg;
	logic [EV_W-1:0]   int_stat_reg;
	logic [EV_W-1:0]   int_stat_next;
	logic [EV_W-1:0]   int_mask_reg;
	logic [EV_W-1:0]   int_mask_next;
	logic [EV_W-1:0]   events;
	logic [NUM_CH-1:0] pending_prev_reg;
	logic              mode_prev_reg;
	logic              bus_mode_sync;
	logic              ovr_pin_sync;
	logic              ovr_eff;
	quiro_bus_mode_t   bus_mode;
	logic [NUM_CH-1:0] irq_en;
	logic [NUM_CH-1:0] irq_out_next;
	logic [NUM_CH-1:0] irq_oe_next;
	logic [NUM_CH-1:0] irq_out_reg;
	logic [NUM_CH-1:0] irq_oe_reg;
	logic [NUM_CH-1:0] tx_n_next;
	logic [NUM_CH-1:0] rx_n_next;
	logic [NUM_CH-1:0] tx_n_reg;
	logic [NUM_CH-1:0] rx_n_reg;
	logic              all_tx_reg;
	logic              all_rx_reg;
	logic              irq_reg;
	logic              setup_phase;
	logic              wr_fire;
	logic              addr_ok;
	logic [DATA_W-1:0] rd_word;
	logic [DATA_W-1:0] prdata_reg;
	logic              pready_reg;
	logic              pslverr_reg;

	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		addr_mapped = (a == OFF_MCR_A) || (a == OFF_MCR_B) || (a == OFF_MCR_C) ||
			(a == OFF_MCR_D) || (a == OFF_DMA_MODE) || (a == OFF_STATUS) ||
			(a == OFF_INT_STAT) || (a == OFF_INT_MASK);
	endfunction

	function automatic logic [1:0] mcr_index(input logic [ADDR_W-1:0] a);
		mcr_index = a[3:2];
	endfunction

	function automatic logic is_mcr(input logic [ADDR_W-1:0] a);
		is_mcr = (a == OFF_MCR_A) || (a == OFF_MCR_B) || (a == OFF_MCR_C) ||
			(a == OFF_MCR_D);
	endfunction

	// ------------------------------------------------------------------------
	// Pin synchronisers and mode decode
	// ------------------------------------------------------------------------
	quiro_sync #(.RESET_VAL(1'b1)) u_mode_sync (
		.pclk      (pclk),
		.presetn   (presetn),
		.pin_in    (bus_mode_select),
		.level_out (bus_mode_sync)
	);

	// Reset value low matches the pad pull-down
	quiro_sync #(.RESET_VAL(1'b0)) u_ovr_sync (
		.pclk      (pclk),
		.presetn   (presetn),
		.pin_in    (irq_override_select),
		.level_out (ovr_pin_sync)
	);

	assign bus_mode = bus_mode_sync ? QUIRO_MODE_SEPARATE : QUIRO_MODE_SINGLE;

	always_comb begin
		case (OVR_TIE)
			QUIRO_OVR_PIN:      ovr_eff = ovr_pin_sync;
			QUIRO_OVR_TIE_HIGH: ovr_eff = 1'b1;
			QUIRO_OVR_TIE_LOW:  ovr_eff = 1'b0;
			default:            ovr_eff = 1'b0;
		endcase
	end

	// ------------------------------------------------------------------------
	// Interrupt pin drive
	// ------------------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			irq_en[i] = ovr_eff | modem_control_reg[i][MCR_IRQ_EN_BIT];
		end
		if (bus_mode == QUIRO_MODE_SEPARATE) begin
			irq_oe_next  = irq_en;
			irq_out_next = chan_irq_pending;
		end else begin
			// Override is ignored here; the host keeps it low anyway
			irq_out_next = '0;
			irq_oe_next  = {{(NUM_CH-1){1'b1}}, |chan_irq_pending};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_out_reg <= '0;
			irq_oe_reg  <= '0;
		end else begin
			irq_out_reg <= irq_out_next;
			irq_oe_reg  <= irq_oe_next;
		end
	end

	assign chan_a_irq_out = irq_out_reg[0];
	assign chan_b_irq_out = irq_out_reg[1];
	assign chan_c_irq_out = irq_out_reg[2];
	assign chan_d_irq_out = irq_out_reg[3];
	assign chan_a_irq_oe  = irq_oe_reg[0];
	assign chan_b_irq_oe  = irq_oe_reg[1];
	assign chan_c_irq_oe  = irq_oe_reg[2];
	assign chan_d_irq_oe  = irq_oe_reg[3];

	// ------------------------------------------------------------------------
	// Ready outputs
	// ------------------------------------------------------------------------
	for (genvar g = 0; g < NUM_CH; g++) begin : g_rdy
		quiro_ready u_rdy (
			.pclk            (pclk),
			.presetn         (presetn),
			.dma_mode        (dma_mode_reg[g]),
			.thr_empty       (thr_empty[g]),
			.tx_fifo_full    (tx_fifo_full[g]),
			.rx_data_avail   (rx_data_avail[g]),
			.rx_trig_hit     (rx_trig_hit[g]),
			.tx_ready_n_next (tx_n_next[g]),
			.rx_ready_n_next (rx_n_next[g]),
			.tx_ready_n_reg  (tx_n_reg[g]),
			.rx_ready_n_reg  (rx_n_reg[g])
		);
	end

	// Combined outputs use next values so they stay aligned with channels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			all_tx_reg <= 1'b1;
			all_rx_reg <= 1'b1;
		end else begin
			all_tx_reg <= &tx_n_next;
			all_rx_reg <= &rx_n_next;
		end
	end

	assign chan_a_tx_ready_n = tx_n_reg[0];
	assign chan_b_tx_ready_n = tx_n_reg[1];
	assign chan_c_tx_ready_n = tx_n_reg[2];
	assign chan_d_tx_ready_n = tx_n_reg[3];
	assign chan_a_rx_ready_n = rx_n_reg[0];
	assign chan_b_rx_ready_n = rx_n_reg[1];
	assign chan_c_rx_ready_n = rx_n_reg[2];
	assign chan_d_rx_ready_n = rx_n_reg[3];
	assign all_tx_ready_n    = all_tx_reg;
	assign all_rx_ready_n    = all_rx_reg;

	// ------------------------------------------------------------------------
	// APB slave: one wait-free access phase, data latched at setup
	// ------------------------------------------------------------------------
	assign setup_phase = psel && !penable && !pready_reg;
	assign wr_fire     = psel && penable && pready_reg && pwrite && !pslverr_reg;
	assign addr_ok     = addr_mapped(paddr);

	always_comb begin
		rd_word = ZERO_WORD;
		if (is_mcr(paddr)) begin
			rd_word[MCR_W-1:0] = modem_control_reg[mcr_index(paddr)];
		end else if (paddr == OFF_DMA_MODE) begin
			rd_word[NUM_CH-1:0] = dma_mode_reg;
		end else if (paddr == OFF_STATUS) begin
			rd_word[ST_TX_LSB +: NUM_CH] = tx_n_reg;
			rd_word[ST_RX_LSB +: NUM_CH] = rx_n_reg;
			rd_word[ST_MODE_BIT]         = bus_mode_sync;
			rd_word[ST_OVR_BIT]          = ovr_eff;
		end else if (paddr == OFF_INT_STAT) begin
			rd_word[EV_W-1:0] = int_stat_reg;
		end else if (paddr == OFF_INT_MASK) begin
			rd_word[EV_W-1:0] = int_mask_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= ZERO_WORD;
		end else if (setup_phase) begin
			pready_reg  <= 1'b1;
			pslverr_reg <= !addr_ok;
			prdata_reg  <= (!pwrite && addr_ok) ? rd_word : ZERO_WORD;
		end else begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= ZERO_WORD;
		end
	end

	assign pready  = pready_reg;
	assign pslverr = pslverr_reg;
	assign prdata  = prdata_reg;

	// ------------------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_CH; i++) begin
				modem_control_reg[i] <= MCR_RESET;
			end
		end else if (wr_fire && is_mcr(paddr)) begin
			modem_control_reg[mcr_index(paddr)] <= pwdata[MCR_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dma_mode_reg <= DMA_RESET;
		end else if (wr_fire && paddr == OFF_DMA_MODE) begin
			dma_mode_reg <= pwdata[NUM_CH-1:0];
		end
	end

	// ------------------------------------------------------------------------
	// Event status, mask and interrupt line
	// ------------------------------------------------------------------------
	always_comb begin
		events                   = '0;
		events[NUM_CH-1:0]       = chan_irq_pending & ~pending_prev_reg;
		events[EV_MODE_BIT]      = bus_mode_sync ^ mode_prev_reg;
		int_stat_next            = int_stat_reg;
		int_mask_next            = int_mask_reg;
		if (wr_fire && paddr == OFF_INT_STAT) begin
			int_stat_next = int_stat_reg & ~pwdata[EV_W-1:0];
		end
		if (wr_fire && paddr == OFF_INT_MASK) begin
			int_mask_next = pwdata[EV_W-1:0];
		end
		// Set wins over a same-cycle clear
		int_stat_next = int_stat_next | events;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending_prev_reg <= '0;
			mode_prev_reg    <= 1'b1;
			int_stat_reg     <= INT_STAT_RESET;
			int_mask_reg     <= INT_MASK_RESET;
			irq_reg          <= 1'b0;
		end else begin
			pending_prev_reg <= chan_irq_pending;
			mode_prev_reg    <= bus_mode_sync;
			int_stat_reg     <= int_stat_next;
			int_mask_reg     <= int_mask_next;
			irq_reg          <= |(int_stat_next & int_mask_next);
		end
	end

	assign irq = irq_reg;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	a_sep_oe_bit: assert property (@(posedge pclk) disable iff (!presetn)
		(bus_mode == QUIRO_MODE_SEPARATE && !ovr_eff)
		|=> (irq_oe_reg[1] == $past(modem_control_reg[1][MCR_IRQ_EN_BIT])))
		else $error("channel B enable does not follow its control bit");

	a_ovr_all_on: assert property (@(posedge pclk) disable iff (!presetn)
		(bus_mode == QUIRO_MODE_SEPARATE && ovr_eff) |=> (&irq_oe_reg))
		else $error("override did not enable all interrupt outputs");

	a_sep_level: assert property (@(posedge pclk) disable iff (!presetn)
		(bus_mode == QUIRO_MODE_SEPARATE) |=> (irq_out_reg == $past(chan_irq_pending)))
		else $error("interrupt level does not follow pending state");

	a_single_od: assert property (@(posedge pclk) disable iff (!presetn)
		(bus_mode == QUIRO_MODE_SINGLE)
		|=> (!chan_a_irq_out && chan_a_irq_oe == $past(|chan_irq_pending)))
		else $error("shared interrupt not open-drain active low");

	a_single_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(bus_mode == QUIRO_MODE_SINGLE)[*2]
		|-> (irq_oe_reg[3:1] == 3'h7 && irq_out_reg[3:1] == 3'h0))
		else $error("unused interrupt pins not held at zero");

	a_tx_and: assert property (@(posedge pclk) disable iff (!presetn)
		all_tx_ready_n == (&tx_n_reg))
		else $error("combined transmit-ready is not the AND");

	a_rx_and: assert property (@(posedge pclk) disable iff (!presetn)
		all_rx_ready_n == (&rx_n_reg))
		else $error("combined receive-ready is not the AND");

	a_tie_variant: assert property (@(posedge pclk) disable iff (!presetn)
		(OVR_TIE == QUIRO_OVR_TIE_HIGH) |-> ovr_eff)
		else $error("tied-high variant lost its override");

	a_rx_mode0: assert property (@(posedge pclk) disable iff (!presetn)
		(!dma_mode_reg[0] && rx_data_avail[0]) |=> !chan_a_rx_ready_n)
		else $error("mode 0 receive-ready not asserted with data");

	a_irq_line: assert property (@(posedge pclk) disable iff (!presetn)
		irq == (|(int_stat_reg & int_mask_reg)))
		else $error("interrupt line does not match masked status");

endmodule

// ==== sim/quiro_host_model.sv ====
/*
 * Host side of the interrupt pins: bus-mode strap, override pin,
 * and the pulled-up shared interrupt line.
 * Assumes the device drives chan_a_irq_out/oe as an open-drain pair.
 */
`timescale 1ns/10ps
module quiro_host_model (
	input  wire logic want_single,
	input  wire logic want_ovr,
	input  wire logic chan_a_irq_out,
	input  wire logic chan_a_irq_oe,
	output logic      bus_mode_select,
	output logic      irq_override_select,
	output logic      irq_level
);
	// ------------------------------------------------------------------
	// Straps and line resolution
	// ------------------------------------------------------------------
	assign bus_mode_select     = !want_single;
	assign irq_override_select = want_single ? 1'b0 : want_ovr;
	// External pull-up; the device can only pull the line low
	assign irq_level = (chan_a_irq_oe && !chan_a_irq_out) ? 1'b0 : 1'b1;
endmodule

// ==== sim/quad_uart_irq_ready_outputs_bench.sv ====
/*
 * Self-checking bench for the interrupt and ready output block.
 * Assumes an APB master at 100 MHz and the host model beside the design.
 */
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
	$display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module quad_uart_irq_ready_outputs_bench;
	import quiro_pkg::*;
	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd;
	logic [NUM_CH-1:0] chan_irq_pending, thr_empty, tx_fifo_full, rx_data_avail, rx_trig_hit;
	logic              bus_mode_select, irq_override_select, want_single, want_ovr, irq_level;
	logic              chan_a_irq_out, chan_a_irq_oe, chan_b_irq_out, chan_b_irq_oe;
	logic              chan_c_irq_out, chan_c_irq_oe, chan_d_irq_out, chan_d_irq_oe;
	logic              chan_a_tx_ready_n, chan_b_tx_ready_n, chan_c_tx_ready_n, chan_d_tx_ready_n;
	logic              chan_a_rx_ready_n, chan_b_rx_ready_n, chan_c_rx_ready_n, chan_d_rx_ready_n;
	logic              all_tx_ready_n, all_rx_ready_n, irq;
	int                fail_count, compares;
	logic [NUM_CH-1:0] tied_oe;

	quiro_top dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .bus_mode_select, .irq_override_select, .chan_irq_pending,
		.thr_empty, .tx_fifo_full, .rx_data_avail, .rx_trig_hit, .chan_a_irq_out,
		.chan_a_irq_oe, .chan_b_irq_out, .chan_b_irq_oe, .chan_c_irq_out, .chan_c_irq_oe,
		.chan_d_irq_out, .chan_d_irq_oe, .chan_a_tx_ready_n, .chan_b_tx_ready_n,
		.chan_c_tx_ready_n, .chan_d_tx_ready_n, .chan_a_rx_ready_n, .chan_b_rx_ready_n,
		.chan_c_rx_ready_n, .chan_d_rx_ready_n, .all_tx_ready_n, .all_rx_ready_n, .irq);
	quiro_host_model host (.want_single, .want_ovr, .chan_a_irq_out, .chan_a_irq_oe,
		.bus_mode_select, .irq_override_select, .irq_level);
	// Variant with the override tied high, fed the same stimulus
	quiro_top #(.OVR_TIE(QUIRO_OVR_TIE_HIGH)) dut_tied (.pclk, .presetn, .paddr, .psel, .penable,
		.pwrite, .pwdata, .prdata(), .pready(), .pslverr(), .bus_mode_select,
		.irq_override_select, .chan_irq_pending, .thr_empty, .tx_fifo_full, .rx_data_avail,
		.rx_trig_hit, .chan_a_irq_out(), .chan_a_irq_oe(tied_oe[0]), .chan_b_irq_out(),
		.chan_b_irq_oe(tied_oe[1]), .chan_c_irq_out(), .chan_c_irq_oe(tied_oe[2]),
		.chan_d_irq_out(), .chan_d_irq_oe(tied_oe[3]), .chan_a_tx_ready_n(),
		.chan_b_tx_ready_n(), .chan_c_tx_ready_n(), .chan_d_tx_ready_n(), .chan_a_rx_ready_n(),
		.chan_b_rx_ready_n(), .chan_c_rx_ready_n(), .chan_d_rx_ready_n(), .all_tx_ready_n(),
		.all_rx_ready_n(), .irq());

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// ------------------------------------------------------------------
	// Bus and timing tasks
	// ------------------------------------------------------------------
	task wrap_up;
		$display("comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		n = 0;
		while (pready !== 1'b1 && n < 16) begin
			n++;
			@(posedge pclk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		if (pready !== 1'b1) begin
			fail_count++;
			wrap_up;
		end
	endtask

	// ------------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------------
	initial begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
		chan_irq_pending = '0; thr_empty = '0; tx_fifo_full = '0; rx_data_avail = '0;
		rx_trig_hit = '0; want_single = 1'b0; want_ovr = 1'b0; fail_count = 0; compares = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		tick(8);
		`CHK({chan_d_irq_oe, chan_c_irq_oe, chan_b_irq_oe, chan_a_irq_oe}, 4'h0)
		`CHK(tied_oe, 4'hf)
		apb(1'b0, OFF_MCR_A, '0);
		`CHK(rd, 32'h0000_0000)
		apb(1'b0, OFF_STATUS, '0);
		`CHK(rd, 32'h0000_01ff)
		apb(1'b1, OFF_INT_MASK, 32'h0000_001f);
		@(posedge pclk);
		chan_irq_pending <= 4'h1;
		tick(2);
		`CHK({irq, chan_a_irq_out}, 2'b11)
		apb(1'b0, OFF_INT_STAT, '0);
		`CHK(rd, 32'h0000_0001)
		apb(1'b1, OFF_INT_STAT, 32'h0000_0001);
		tick(2);
		`CHK(irq, 1'b0)
		apb(1'b1, OFF_INT_MASK, '0);
		@(posedge pclk);
		chan_irq_pending <= 4'h3;
		tick(2);
		`CHK(irq, 1'b0)
		apb(1'b0, OFF_INT_STAT, '0);
		`CHK(rd, 32'h0000_0002)
		apb(1'b1, OFF_MCR_B, 32'h0000_0008);
		tick(2);
		`CHK({chan_d_irq_oe, chan_c_irq_oe, chan_b_irq_oe, chan_a_irq_oe}, 4'h2)
		`CHK(chan_b_irq_out, 1'b1)
		@(posedge pclk);
		chan_irq_pending <= 4'h1;
		tick(2);
		`CHK(chan_b_irq_out, 1'b0)
		@(posedge pclk);
		want_ovr <= 1'b1;
		tick(8);
		`CHK({chan_d_irq_oe, chan_c_irq_oe, chan_b_irq_oe, chan_a_irq_oe}, 4'hf)
		@(posedge pclk);
		want_single <= 1'b1;
		tick(8);
		`CHK({chan_a_irq_oe, chan_a_irq_out, irq_level}, 3'b100)
		`CHK({chan_b_irq_oe, chan_c_irq_oe, chan_d_irq_oe, chan_b_irq_out, chan_c_irq_out,
			chan_d_irq_out}, 6'b111000)
		@(posedge pclk);
		chan_irq_pending <= 4'h0;
		tick(2);
		`CHK(irq_level, 1'b1)
		`CHK(tied_oe, 4'he)
		apb(1'b0, OFF_INT_STAT, '0);
		`CHK(rd, 32'h0000_0012)
		@(posedge pclk);
		thr_empty <= 4'h1;
		rx_data_avail <= 4'h8;
		tick(2);
		`CHK({chan_d_tx_ready_n, chan_c_tx_ready_n, chan_b_tx_ready_n, chan_a_tx_ready_n}, 4'he)
		`CHK({chan_d_rx_ready_n, chan_c_rx_ready_n, chan_b_rx_ready_n, chan_a_rx_ready_n}, 4'h7)
		`CHK({all_tx_ready_n, all_rx_ready_n}, 2'b00)
		@(posedge pclk);
		thr_empty <= 4'h0;
		rx_data_avail <= 4'h0;
		tick(2);
		`CHK({all_tx_ready_n, all_rx_ready_n}, 2'b11)
		apb(1'b1, OFF_DMA_MODE, 32'h0000_0001);
		@(posedge pclk);
		rx_data_avail <= 4'h1;
		tick(2);
		`CHK(chan_a_rx_ready_n, 1'b1)
		@(posedge pclk);
		rx_trig_hit <= 4'h1;
		tick(2);
		`CHK(chan_a_rx_ready_n, 1'b0)
		@(posedge pclk);
		rx_trig_hit <= 4'h0;
		tick(2);
		`CHK(chan_a_rx_ready_n, 1'b0)
		@(posedge pclk);
		thr_empty <= 4'h1;
		tick(2);
		`CHK(chan_a_tx_ready_n, 1'b0)
		@(posedge pclk);
		thr_empty <= 4'h0;
		tick(2);
		`CHK(chan_a_tx_ready_n, 1'b0)
		@(posedge pclk);
		tx_fifo_full <= 4'h1;
		tick(2);
		`CHK({chan_a_tx_ready_n, all_tx_ready_n}, 2'b11)
		apb(1'b0, 8'h20, '0);
		`CHK({er, rd}, {1'b1, 32'h0000_0000})
		wrap_up;
	end
endmodule
